// ===== rtl/dfpc_pkg.sv
/*
  Constants, encodings and timing counts of the drive frequency profile
  control block. Assumes a 125 MHz system clock.
*/
package dfpc_pkg;
  // frequencies in 0.01 Hz, voltages in 0.01 V, times in 0.1 s
  localparam int FREQ_W = 16;
  localparam int VOLT_W = 16;
  localparam int TIME_W = 14;
  localparam logic [15:0] FREQ_MAX_LIMIT = 16'h9C40;
  localparam logic [15:0] VOLT_MAX_LIMIT = 16'hC350;
  localparam logic [13:0] TIME_MIN = 14'h0001;
  localparam logic [13:0] TIME_MAX = 14'h270F;
  localparam logic [15:0] RST_CEILING = 16'h1388;
  localparam logic [15:0] RST_FLOOR = 16'h0000;
  localparam logic [15:0] RST_SETPOINT = 16'h1388;
  localparam logic [13:0] RST_RAMP = 14'h0050;
  localparam logic [15:0] RST_TOP_VOLT = 16'h9470;
  localparam logic [15:0] RST_BASE_FREQ = 16'h1388;
  localparam logic [15:0] RST_MID_VOLT = 16'h07D0;
  localparam logic [15:0] RST_MID_FREQ = 16'h00FA;
  localparam logic [15:0] RST_LOW_VOLT = 16'h05DC;
  localparam logic [15:0] RST_LOW_FREQ = 16'h007D;
  localparam logic [3:0] RST_SWITCH = 4'hA;
  localparam logic [15:0] RST_START_FREQ = 16'h0032;
  localparam logic [15:0] RST_STOP_FREQ = 16'h0032;
  localparam logic [15:0] START_STOP_MIN = 16'h000A;
  localparam logic [15:0] START_STOP_MAX = 16'h03E8;
  localparam logic [3:0] SWITCH_MIN = 4'h1;
  localparam logic [3:0] SWITCH_MAX = 4'hF;
  localparam logic [3:0] RESTORE_CODE = 4'h8;
  // control tick of 100 us: each ramp step is ceiling/(time*1000) per tick
  localparam int TICK_NS = 100000;
  localparam int CLK_NS = 8;
  localparam int TICK_CYCLES = TICK_NS / CLK_NS;
  localparam int TICKS_PER_TENTH = 1000;
  // trace sweep step per tick, 0.01 Hz
  localparam logic [15:0] TRACE_STEP = 16'h0001;

  typedef enum logic [4:0] {
    DFPC_IDLE  = 5'h01,
    DFPC_TRACE = 5'h02,
    DFPC_RUN   = 5'h04,
    DFPC_DECEL = 5'h08,
    DFPC_COAST = 5'h10
  } dfpc_state_type;

  // parameter indices for the write port
  typedef enum logic [3:0] {
    DFPC_P_SETPOINT = 4'h0, DFPC_P_REVERSE = 4'h1,
    DFPC_P_CEILING = 4'h2, DFPC_P_FLOOR = 4'h3,
    DFPC_P_UP = 4'h4, DFPC_P_DOWN = 4'h5,
    DFPC_P_TOPV = 4'h6, DFPC_P_BASEF = 4'h7,
    DFPC_P_MIDV = 4'h8, DFPC_P_MIDF = 4'h9,
    DFPC_P_LOWV = 4'hA, DFPC_P_LOWF = 4'hB,
    DFPC_P_SWITCH = 4'hC, DFPC_P_RESTORE = 4'hD,
    DFPC_P_LOCK = 4'hE, DFPC_P_STARTSTOP = 4'hF
  } dfpc_param_type;
endpackage

// ===== rtl/dfpc_ramp_step.sv
/*
  Ramp step calculator: step per control tick for a given ceiling and
  ramp time, by serial division. Assumes inputs hold while busy.
*/
`timescale 1ns/1ns
`default_nettype none
module dfpc_ramp_step #(
  parameter int W = 16
) (
  input  wire logic         clk_sys,
  input  wire logic         rstn,
  input  wire logic         start,
  input  wire logic [W-1:0] ceiling,
  input  wire logic [13:0]  ramp_time,
  output var  logic [W+7:0] step,
  output var  logic         done
);
  typedef struct packed {
    logic [W+7:0] quot;
    logic [W+7:0] rem;
    logic [5:0]   cnt;
    logic         busy;
    logic [W+7:0] step;
    logic         done;
  } dfpc_div_type;

  dfpc_div_type cur;
  dfpc_div_type next_cur;
  logic [W+7:0] divisor;
  logic [W+8:0] trial;

  // fraction carries 8 bits so slow ramps still move
  always_comb begin
    divisor = (W+8)'(ramp_time) * (W+8)'(dfpc_pkg::TICKS_PER_TENTH);
    next_cur = cur;
    next_cur.done = 1'b0;
    trial = '0;
    if (start) begin
      next_cur.quot = {ceiling, 8'h00};
      next_cur.rem = '0;
      next_cur.cnt = 6'(W + 8);
      next_cur.busy = 1'b1;
    end else if (cur.busy) begin
      trial = {cur.rem, cur.quot[W+7]};
      next_cur.quot = {cur.quot[W+6:0], 1'b0};
      if (trial >= {1'b0, divisor}) begin
        next_cur.rem = (W+8)'(trial - {1'b0, divisor});
        next_cur.quot[0] = 1'b1;
      end else begin
        next_cur.rem = trial[W+7:0];
      end
      next_cur.cnt = cur.cnt - 6'h01;
      if (cur.cnt == 6'h01) begin
        next_cur.busy = 1'b0;
        next_cur.done = 1'b1;
        next_cur.step = {cur.quot[W+6:0], next_cur.quot[0]};
        if (next_cur.step == '0) begin
          next_cur.step = (W+8)'(1);
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign step = cur.step;
  assign done = cur.done;
endmodule
`default_nettype wire

// ===== rtl/dfpc_vf_curve.sv
/*
  V/F curve: output voltage for a frequency by linear interpolation
  between the low, mid and base points. Combinational; assumes points
  are ascending.
*/
`timescale 1ns/1ns
`default_nettype none
module dfpc_vf_curve (
  input  wire logic [15:0] freq,
  input  wire logic [15:0] low_f,
  input  wire logic [15:0] low_v,
  input  wire logic [15:0] mid_f,
  input  wire logic [15:0] mid_v,
  input  wire logic [15:0] base_f,
  input  wire logic [15:0] top_v,
  output var  logic [15:0] volt
);
  function automatic logic [15:0] lerp(
    input logic [15:0] f,
    input logic [15:0] f0,
    input logic [15:0] v0,
    input logic [15:0] f1,
    input logic [15:0] v1
  );
    logic [31:0] num;
    logic [15:0] span;
    num = 32'(f - f0) * 32'(v1 - v0);
    span = (f1 > f0) ? (f1 - f0) : 16'h0001;
    lerp = v0 + 16'(num / 32'(span));
  endfunction

  always_comb begin
    if (freq <= low_f) begin
      volt = low_v;
    end else if (freq <= mid_f) begin
      volt = lerp(freq, low_f, low_v, mid_f, mid_v);
    end else if (freq < base_f) begin
      volt = lerp(freq, mid_f, mid_v, base_f, top_v);
    end else begin
      volt = top_v;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/dfpc_top.sv
/*
  Drive frequency profile control: parameter store with write lock and
  factory restore, setpoint clamp, ramp generator, start and stop
  sequencing, trace start and V/F voltage. Assumes all inputs are
  synchronous to clk_sys and the speed estimate comes from outside.
*/
`timescale 1ns/1ns
`default_nettype none
module dfpc_top (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        param_we,
  input  wire logic [3:0]  param_sel,
  input  wire logic [15:0] param_wdata,
  input  wire logic        param_alt,
  input  wire logic        alt_ramp_sel,
  input  wire logic [13:0] alt_ramp_up_time,
  input  wire logic [13:0] alt_ramp_down_time,
  input  wire logic        run_cmd,
  input  wire logic        dir_reverse_cmd,
  input  wire logic        dc_brake_select,
  input  wire logic        over_current,
  input  wire logic        speed_match,
  input  wire logic        motor_dir_reverse,
  output var  logic        param_refused,
  output var  logic [15:0] out_freq,
  output var  logic [15:0] out_volt,
  output var  logic        out_reverse,
  output var  logic        out_enable,
  output var  logic        stop_reached,
  output var  logic [3:0]  switching_rate_select,
  output var  logic        param_write_lock
);
  typedef struct packed {
    logic [15:0] main_freq_setpoint;
    logic        reverse_permit;
    logic [15:0] freq_ceiling;
    logic [15:0] freq_floor;
    logic [13:0] ramp_up_time;
    logic [13:0] ramp_down_time;
    logic [15:0] vf_top_voltage;
    logic [15:0] vf_base_freq;
    logic [15:0] vf_mid_voltage;
    logic [15:0] vf_mid_freq;
    logic [15:0] vf_low_voltage;
    logic [15:0] vf_low_freq;
    logic [3:0]  switching_rate_select;
    logic        lock;
    logic        start_method;
    logic        stop_method;
    logic [15:0] start_freq;
    logic [15:0] stop_freq;
    dfpc_pkg::dfpc_state_type st;
    logic [23:0] freq_acc;
    logic        reverse;
    logic [16:0] tick_cnt;
    logic        tick;
    logic        refused;
    logic        stop_reached;
    logic [15:0] volt;
    logic        div_go;
    logic        div_up;
    logic [23:0] up_step;
    logic [23:0] down_step;
    logic [28:0] alt_seen;
    logic        out_en;
    logic [15:0] out_freq;
  } dfpc_state_type_all;

  dfpc_state_type_all cur;
  dfpc_state_type_all next_cur;
  logic [15:0] target;
  logic [15:0] freq_now;
  logic [15:0] volt_calc;
  logic [23:0] div_step;
  logic        div_done;
  logic [13:0] div_time;
  logic        accept;
  dfpc_state_type_all before_wr;

  function automatic logic [15:0] clamp(
    input logic [15:0] v,
    input logic [15:0] lo,
    input logic [15:0] hi
  );
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic logic [13:0] pick_time(
    input logic        alt,
    input logic [13:0] prim,
    input logic [13:0] sec
  );
    pick_time = alt ? 14'(clamp({2'b00, sec}, {2'b00, dfpc_pkg::TIME_MIN},
                                {2'b00, dfpc_pkg::TIME_MAX}))
                    : prim;
  endfunction

  assign freq_now = cur.freq_acc[23:8];
  assign target = clamp(cur.main_freq_setpoint, cur.freq_floor,
                        cur.freq_ceiling);
  assign div_time = cur.div_up
      ? pick_time(alt_ramp_sel, cur.ramp_up_time, alt_ramp_up_time)
      : pick_time(alt_ramp_sel, cur.ramp_down_time, alt_ramp_down_time);

  dfpc_ramp_step #(
    .W(16)
  ) u_step (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .start    (cur.div_go),
    .ceiling  (cur.freq_ceiling),
    .ramp_time(div_time),
    .step     (div_step),
    .done     (div_done)
  );

  dfpc_vf_curve u_vf (
    .freq  (freq_now),
    .low_f (cur.vf_low_freq),
    .low_v (cur.vf_low_voltage),
    .mid_f (cur.vf_mid_freq),
    .mid_v (cur.vf_mid_voltage),
    .base_f(cur.vf_base_freq),
    .top_v (cur.vf_top_voltage),
    .volt  (volt_calc)
  );

  function automatic dfpc_state_type_all factory(
    input dfpc_state_type_all s
  );
    dfpc_state_type_all r;
    r = s;
    r.main_freq_setpoint = dfpc_pkg::RST_SETPOINT;
    r.reverse_permit = 1'b1;
    r.freq_ceiling = dfpc_pkg::RST_CEILING;
    r.freq_floor = dfpc_pkg::RST_FLOOR;
    r.ramp_up_time = dfpc_pkg::RST_RAMP;
    r.ramp_down_time = dfpc_pkg::RST_RAMP;
    r.vf_top_voltage = dfpc_pkg::RST_TOP_VOLT;
    r.vf_base_freq = dfpc_pkg::RST_BASE_FREQ;
    r.vf_mid_voltage = dfpc_pkg::RST_MID_VOLT;
    r.vf_mid_freq = dfpc_pkg::RST_MID_FREQ;
    r.vf_low_voltage = dfpc_pkg::RST_LOW_VOLT;
    r.vf_low_freq = dfpc_pkg::RST_LOW_FREQ;
    r.switching_rate_select = dfpc_pkg::RST_SWITCH;
    r.lock = 1'b0;
    r.start_method = 1'b0;
    r.stop_method = 1'b0;
    r.start_freq = dfpc_pkg::RST_START_FREQ;
    r.stop_freq = dfpc_pkg::RST_STOP_FREQ;
    r.div_go = 1'b1;
    r.div_up = 1'b1;
    factory = r;
  endfunction

  always_comb begin
    next_cur = cur;
    next_cur.refused = 1'b0;
    next_cur.div_go = 1'b0;
    accept = 1'b0;
    // control tick divider
    next_cur.tick = 1'b0;
    if (cur.tick_cnt == 17'(dfpc_pkg::TICK_CYCLES - 1)) begin
      next_cur.tick_cnt = '0;
      next_cur.tick = 1'b1;
    end else begin
      next_cur.tick_cnt = cur.tick_cnt + 17'h00001;
    end
    // recompute ramp steps: up, then down
    if (div_done) begin
      if (cur.div_up) begin
        next_cur.up_step = div_step;
        next_cur.div_up = 1'b0;
        next_cur.div_go = 1'b1;
      end else begin
        next_cur.down_step = div_step;
        next_cur.div_up = 1'b1;
      end
    end
    // a new alternate selection or time needs fresh steps
    next_cur.alt_seen = {alt_ramp_sel, alt_ramp_up_time, alt_ramp_down_time};
    if (next_cur.alt_seen != cur.alt_seen) begin
      next_cur.div_go = 1'b1;
      next_cur.div_up = 1'b1;
    end
    before_wr = next_cur;
    if (param_we) begin
      if (cur.lock && param_sel != dfpc_pkg::DFPC_P_SETPOINT &&
          param_sel != dfpc_pkg::DFPC_P_LOCK) begin
        next_cur.refused = 1'b1;
      end else begin
        unique case (param_sel)
          dfpc_pkg::DFPC_P_SETPOINT: begin
            accept = 1'b1;
            next_cur.main_freq_setpoint = param_wdata;
          end
          dfpc_pkg::DFPC_P_REVERSE: begin
            accept = param_wdata <= 16'h0001;
            next_cur.reverse_permit = param_wdata[0];
          end
          dfpc_pkg::DFPC_P_CEILING: begin
            accept = param_wdata <= dfpc_pkg::FREQ_MAX_LIMIT &&
                     param_wdata >= cur.freq_floor &&
                     param_wdata >= cur.vf_base_freq;
            next_cur.freq_ceiling = param_wdata;
          end
          dfpc_pkg::DFPC_P_FLOOR: begin
            accept = param_wdata <= cur.freq_ceiling;
            next_cur.freq_floor = param_wdata;
          end
          dfpc_pkg::DFPC_P_UP, dfpc_pkg::DFPC_P_DOWN: begin
            accept = param_wdata >= {2'b00, dfpc_pkg::TIME_MIN} &&
                     param_wdata <= {2'b00, dfpc_pkg::TIME_MAX};
            if (param_sel == dfpc_pkg::DFPC_P_UP) begin
              next_cur.ramp_up_time = param_wdata[13:0];
            end else begin
              next_cur.ramp_down_time = param_wdata[13:0];
            end
          end
          dfpc_pkg::DFPC_P_TOPV: begin
            accept = param_wdata >= cur.vf_mid_voltage &&
                     param_wdata <= dfpc_pkg::VOLT_MAX_LIMIT;
            next_cur.vf_top_voltage = param_wdata;
          end
          dfpc_pkg::DFPC_P_BASEF: begin
            accept = param_wdata >= cur.vf_mid_freq &&
                     param_wdata <= cur.freq_ceiling;
            next_cur.vf_base_freq = param_wdata;
          end
          dfpc_pkg::DFPC_P_MIDV: begin
            accept = param_wdata >= cur.vf_low_voltage &&
                     param_wdata <= cur.vf_top_voltage;
            next_cur.vf_mid_voltage = param_wdata;
          end
          dfpc_pkg::DFPC_P_MIDF: begin
            accept = param_wdata >= cur.vf_low_freq &&
                     param_wdata <= cur.vf_base_freq;
            next_cur.vf_mid_freq = param_wdata;
          end
          dfpc_pkg::DFPC_P_LOWV: begin
            accept = param_wdata <= cur.vf_mid_voltage;
            next_cur.vf_low_voltage = param_wdata;
          end
          dfpc_pkg::DFPC_P_LOWF: begin
            accept = param_wdata <= cur.vf_mid_freq;
            next_cur.vf_low_freq = param_wdata;
          end
          dfpc_pkg::DFPC_P_SWITCH: begin
            accept = param_wdata >= {12'h000, dfpc_pkg::SWITCH_MIN} &&
                     param_wdata <= {12'h000, dfpc_pkg::SWITCH_MAX};
            next_cur.switching_rate_select = param_wdata[3:0];
          end
          dfpc_pkg::DFPC_P_RESTORE: begin
            accept = param_wdata <= {12'h000, dfpc_pkg::RESTORE_CODE};
          end
          dfpc_pkg::DFPC_P_LOCK: begin
            accept = param_wdata <= 16'h0001;
            next_cur.lock = param_wdata[0];
          end
          dfpc_pkg::DFPC_P_STARTSTOP: begin
            // param_alt: 0 start freq, 1 stop freq; bits 15:14 methods
            accept = param_wdata[11:0] >= dfpc_pkg::START_STOP_MIN[11:0] &&
                     param_wdata[11:0] <= dfpc_pkg::START_STOP_MAX[11:0];
            next_cur.start_method = param_wdata[15];
            next_cur.stop_method = param_wdata[14];
            if (param_alt) begin
              next_cur.stop_freq = {4'h0, param_wdata[11:0]};
            end else begin
              next_cur.start_freq = {4'h0, param_wdata[11:0]};
            end
          end
        endcase
        if (!accept) begin
          // undo only the write; tick and divider keep running
          next_cur = before_wr;
          next_cur.refused = 1'b1;
        end else if (param_sel == dfpc_pkg::DFPC_P_RESTORE &&
                     param_wdata[3:0] == dfpc_pkg::RESTORE_CODE) begin
          next_cur = factory(next_cur);
        end else if (param_sel == dfpc_pkg::DFPC_P_CEILING ||
                     param_sel == dfpc_pkg::DFPC_P_UP ||
                     param_sel == dfpc_pkg::DFPC_P_DOWN) begin
          next_cur.div_go = 1'b1;
          next_cur.div_up = 1'b1;
        end
      end
    end
    next_cur.stop_reached = 1'b0;
    unique case (cur.st)
      dfpc_pkg::DFPC_IDLE, dfpc_pkg::DFPC_COAST: begin
        next_cur.freq_acc = '0;
        if (run_cmd) begin
          next_cur.reverse = dir_reverse_cmd & cur.reverse_permit;
          if (cur.start_method) begin
            next_cur.st = dfpc_pkg::DFPC_TRACE;
            next_cur.freq_acc = {cur.freq_ceiling, 8'h00};
            next_cur.reverse = motor_dir_reverse & cur.reverse_permit;
          end else begin
            next_cur.st = dfpc_pkg::DFPC_RUN;
            next_cur.freq_acc = {clamp(cur.start_freq, 16'h0000,
                                 cur.freq_ceiling), 8'h00};
          end
        end else begin
          next_cur.st = dfpc_pkg::DFPC_IDLE;
        end
      end
      dfpc_pkg::DFPC_TRACE: begin
        if (!run_cmd) begin
          next_cur.st = dfpc_pkg::DFPC_COAST;
        end else if (speed_match || freq_now <= cur.freq_floor) begin
          next_cur.st = dfpc_pkg::DFPC_RUN;
        end else if (cur.tick && !over_current) begin
          next_cur.freq_acc = cur.freq_acc -
                              {dfpc_pkg::TRACE_STEP, 8'h00};
        end
      end
      dfpc_pkg::DFPC_RUN: begin
        if (!run_cmd) begin
          next_cur.st = cur.stop_method ? dfpc_pkg::DFPC_COAST
                                        : dfpc_pkg::DFPC_DECEL;
          if (cur.stop_method) begin
            next_cur.freq_acc = '0;
          end
        end else begin
          if (cur.reverse_permit &&
              dir_reverse_cmd != cur.reverse &&
              freq_now == 16'h0000) begin
            next_cur.reverse = dir_reverse_cmd;
          end
          if (cur.tick) begin
            // direction change ramps down through zero first
            if ((cur.reverse_permit && dir_reverse_cmd != cur.reverse) ||
                freq_now > target) begin
              next_cur.freq_acc = (cur.freq_acc > cur.down_step)
                  ? cur.freq_acc - cur.down_step : 24'h000000;
              if (!(cur.reverse_permit && dir_reverse_cmd != cur.reverse) &&
                  next_cur.freq_acc[23:8] < target) begin
                next_cur.freq_acc = {target, 8'h00};
              end
            end else if (freq_now < target) begin
              next_cur.freq_acc = cur.freq_acc + cur.up_step;
              if (next_cur.freq_acc[23:8] >= target ||
                  next_cur.freq_acc < cur.freq_acc) begin
                next_cur.freq_acc = {target, 8'h00};
              end
            end
          end
        end
      end
      dfpc_pkg::DFPC_DECEL: begin
        if (run_cmd) begin
          next_cur.st = dfpc_pkg::DFPC_RUN;
        end else if (freq_now <= cur.stop_freq) begin
          next_cur.stop_reached = 1'b1;
          next_cur.freq_acc = '0;
          // braking is handled outside; both paths drop output here
          next_cur.st = dfpc_pkg::DFPC_COAST;
        end else if (cur.tick) begin
          next_cur.freq_acc = (cur.freq_acc > cur.down_step)
              ? cur.freq_acc - cur.down_step : 24'h000000;
        end
      end
      default: begin
        next_cur.st = dfpc_pkg::DFPC_IDLE;
      end
    endcase
    next_cur.volt = (cur.st == dfpc_pkg::DFPC_RUN ||
                     cur.st == dfpc_pkg::DFPC_TRACE ||
                     cur.st == dfpc_pkg::DFPC_DECEL)
                    ? volt_calc : 16'h0000;
    next_cur.out_en = next_cur.st != dfpc_pkg::DFPC_IDLE &&
                      next_cur.st != dfpc_pkg::DFPC_COAST;
    next_cur.out_freq = next_cur.out_en ? next_cur.freq_acc[23:8]
                                        : 16'h0000;
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cur <= '0;
      cur.st <= dfpc_pkg::DFPC_IDLE;
      cur.main_freq_setpoint <= dfpc_pkg::RST_SETPOINT;
      cur.reverse_permit <= 1'b1;
      cur.freq_ceiling <= dfpc_pkg::RST_CEILING;
      cur.freq_floor <= dfpc_pkg::RST_FLOOR;
      cur.ramp_up_time <= dfpc_pkg::RST_RAMP;
      cur.ramp_down_time <= dfpc_pkg::RST_RAMP;
      cur.vf_top_voltage <= dfpc_pkg::RST_TOP_VOLT;
      cur.vf_base_freq <= dfpc_pkg::RST_BASE_FREQ;
      cur.vf_mid_voltage <= dfpc_pkg::RST_MID_VOLT;
      cur.vf_mid_freq <= dfpc_pkg::RST_MID_FREQ;
      cur.vf_low_voltage <= dfpc_pkg::RST_LOW_VOLT;
      cur.vf_low_freq <= dfpc_pkg::RST_LOW_FREQ;
      cur.switching_rate_select <= dfpc_pkg::RST_SWITCH;
      cur.start_freq <= dfpc_pkg::RST_START_FREQ;
      cur.stop_freq <= dfpc_pkg::RST_STOP_FREQ;
      cur.div_go <= 1'b1;
      cur.div_up <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  assign param_refused = cur.refused;
  assign out_freq = cur.out_freq;
  assign out_volt = cur.volt;
  assign out_reverse = cur.reverse;
  assign out_enable = cur.out_en;
  assign stop_reached = cur.stop_reached;
  assign switching_rate_select = cur.switching_rate_select;
  assign param_write_lock = cur.lock;
endmodule
`default_nettype wire

// ===== tb/dfpc_motor_model.sv
/*
  Motor behind the power stage: reports surge current and speed match.
  Assumes drive outputs of dfpc_top and commands from the testbench.
*/
`timescale 1ns/1ns
`default_nettype none
module dfpc_motor_model (
  input  wire logic        clk_sys,
  input  wire logic [15:0] drive_freq,
  input  wire logic        drive_en,
  input  wire logic [15:0] spin_freq,
  input  wire logic        surge,
  output var  logic        over_current,
  output var  logic        speed_match
);
  always_ff @(posedge clk_sys) begin
    over_current <= surge && drive_en;
    speed_match  <= drive_en && drive_freq <= spin_freq;
  end
endmodule
`default_nettype wire

// ===== tb/dfpc_top_monitor.sv
/*
  Port checker of dfpc_top; bound to every dfpc_top instance.
*/
`timescale 1ns/1ns
`default_nettype none
module dfpc_top_monitor (
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic        param_we,
  input wire logic [3:0]  param_sel,
  input wire logic [15:0] param_wdata,
  input wire logic        param_refused,
  input wire logic [15:0] out_freq,
  input wire logic [15:0] out_volt,
  input wire logic        out_reverse,
  input wire logic        out_enable,
  input wire logic        stop_reached,
  input wire logic [3:0]  switching_rate_select,
  input wire logic        param_write_lock
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  wire logic       wr_ok = param_we && !param_write_lock;
  wire logic [3:0] wd4   = param_wdata[3:0];
  sequence s_idle2; !out_enable ##1 !out_enable; endsequence
  property p_ceil; out_freq <= dfpc_pkg::FREQ_MAX_LIMIT; endproperty
  a_ceil: assert property (p_ceil) else $error("freq above limit");
  property p_lock; param_write_lock && param_we && param_sel inside
    {4'hC, 4'hD} |=> param_refused && $stable(switching_rate_select);
  endproperty
  a_lock: assert property (p_lock) else $error("locked write taken");
  property p_lkset; param_we && param_sel == 4'hE &&
    param_wdata == 16'h0001 |=> param_write_lock; endproperty
  a_lkset: assert property (p_lkset) else $error("lock not set");
  property p_sw; wr_ok && param_sel == 4'hC && param_wdata inside
    {[16'h0001:16'h000F]} |=> switching_rate_select == $past(wd4);
  endproperty
  a_sw: assert property (p_sw) else $error("rate not taken");
  property p_swbad; wr_ok && param_sel == 4'hC &&
    param_wdata == 16'h0000 |=> param_refused; endproperty
  a_swbad: assert property (p_swbad) else $error("bad rate taken");
  property p_rst; wr_ok && param_sel == 4'hD && param_wdata == 16'h0008
    |=> switching_rate_select == dfpc_pkg::RST_SWITCH; endproperty
  a_rst: assert property (p_rst) else $error("restore missed");
  property p_stop; stop_reached |-> !out_enable && out_freq == 0;
  endproperty
  a_stop: assert property (p_stop) else $error("no coast");
  property p_volt; s_idle2 |-> out_volt == 16'h0000; endproperty
  a_volt: assert property (p_volt) else $error("volt while idle");
  property p_off; $fell(out_enable) |-> out_freq == 16'h0000; endproperty
  a_off: assert property (p_off) else $error("freq kept");
endmodule
bind dfpc_top dfpc_top_monitor dfpc_top_monitor_i (.clk_sys, .rstn,
  .param_we, .param_sel, .param_wdata, .param_refused, .out_freq,
  .out_volt, .out_reverse, .out_enable, .stop_reached,
  .switching_rate_select, .param_write_lock);
`default_nettype wire

// ===== tb/test_drive_frequency_profile_control.sv
/*
  Testbench of dfpc_top with motor model. Assumes the bound checker.
*/
`timescale 1ns/1ns
`default_nettype none
module test_drive_frequency_profile_control;
  logic clk_sys = 0, rstn = 0, we = 0, alt = 0, run = 0, rcmd = 0;
  logic surge = 0, asel = 0;
  logic [3:0] sel = 4'h0;
  logic [15:0] wd = 16'h0000, spin = 16'h0000;
  wire logic oc, match, refd, rev, en, stp, lck;
  wire logic [15:0] f, v;
  wire logic [3:0] sw;
  int n_fail = 0, num_checks = 0, cyc = 0;
  dfpc_top dfpc_top_i (.clk_sys, .rstn, .param_we(we), .param_sel(sel),
    .param_wdata(wd), .param_alt(alt), .alt_ramp_sel(asel),
    .alt_ramp_up_time(14'h0001), .alt_ramp_down_time(14'h0001),
    .run_cmd(run), .dir_reverse_cmd(rcmd), .dc_brake_select(1'b0),
    .over_current(oc), .speed_match(match), .motor_dir_reverse(1'b0),
    .param_refused(refd), .out_freq(f), .out_volt(v), .out_reverse(rev),
    .out_enable(en), .stop_reached(stp), .switching_rate_select(sw),
    .param_write_lock(lck));
  dfpc_motor_model dfpc_motor_model_i (.clk_sys, .drive_freq(f),
    .drive_en(en), .spin_freq(spin), .surge, .over_current(oc),
    .speed_match(match));
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic test_done;
    if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] s, input logic [15:0] d,
                    input logic a, input logic r);
    sel = s; wd = d; alt = a; we = 1;
    tick(1);
    we = 0;
    chk(16'(refd), 16'(r));
    tick(1);
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      n_fail++;
      test_done;
    end
  end
  initial begin
    tick(6); rstn = 1; tick(100);
    chk(16'(sw), 16'h000A); chk(16'(lck), 16'h0000);
    wr(4'hC, 16'h0000, 0, 1); wr(4'hC, 16'h0005, 0, 0);
    chk(16'(sw), 16'h0005);
    wr(4'h7, 16'h0000, 0, 1); wr(4'hB, 16'h012C, 0, 1);
    wr(4'hE, 16'h0001, 0, 0); chk(16'(lck), 16'h0001);
    wr(4'hC, 16'h0003, 0, 1); wr(4'hD, 16'h0008, 0, 1);
    wr(4'h0, 16'h0014, 0, 0); wr(4'hE, 16'h0000, 0, 0);
    wr(4'hD, 16'h0008, 0, 0); chk(16'(sw), 16'h000A);
    wr(4'h0, 16'h0014, 0, 0); wr(4'h1, 16'h0000, 0, 0);
    wr(4'h3, 16'h003C, 0, 0); wr(4'h4, 16'h0001, 0, 0);
    tick(100);
    rcmd = 1; run = 1; tick(1);
    chk(f, 16'h0032); chk(16'(en), 16'h0001);
    for (int i = 0; i < 12600 && f === 16'h0032; i++) tick(1);
    chk(f, 16'h0037);
    tick(25100); chk(f, 16'h003C); chk(16'(rev), 16'h0000);
    wr(4'hF, 16'h4032, 0, 0); wr(4'hF, 16'h4032, 1, 0);
    run = 0; rcmd = 0; tick(1);
    chk(f, 16'h0000); chk(16'(en), 16'h0000);
    wr(4'hF, 16'h0032, 0, 0); wr(4'hF, 16'h002D, 1, 0);
    asel = 1; run = 1; tick(5); run = 0;
    for (int i = 0; i < 13000 && f === 16'h0032; i++) tick(1);
    chk(f, 16'h002D);
    tick(1); chk(16'(stp), 16'h0001);
    wr(4'hF, 16'h8032, 0, 0);
    spin = 16'h1387; surge = 1; run = 1; tick(1);
    chk(f, 16'h1388);
    tick(13000); chk(f, 16'h1388); surge = 0;
    for (int i = 0; i < 13000 && f === 16'h1388; i++) tick(1);
    chk(f, 16'h1387);
    test_done;
  end
endmodule
`default_nettype wire
